/* File: hdl/cfg_eeprom_dev.sv */
// eeprom end of the two-wire programming link
// assumes link pins asynchronous to ref_clk_i, clock from the programmer
// Behaviour
// - read starts like write, select bit one
// - counter holds last accessed address plus one
// - counter kept only while select stays low
// - write at page end points to next page
// - after read address ack, shift current byte
// - programmer stops after single byte read
// - random read: dummy write, restart, read
// - counter increments after each byte sent; programmer ack gets next byte
// - ack at top address wraps to zero
// - programmer ends sequential read with nack, stop
// - identity bytes via random read, special address
// - identity bytes sent lsb first
// - programmer writes whole pages, any order
// - new first byte hidden until power cycle
// - programmer reads back and compares everything; the bench reads back and compares only a few bytes
// - pages rewrite without touching other pages
// - access only while select held low
// - programmer holds fpga reset with select
// - address msb first, data lsb first
// - three address bytes, msb first, each acked
// - no ack while write cycle runs
`timescale 1ns/1ps
`default_nettype none
`include "cfg_eeprom_consts.svh"

module cfg_eeprom_dev
	import cfg_eeprom_pkg::*;
#(
	parameter int        MEM_BYTES = `CFG_MEM_BYTES,
	parameter int        WR_CYCLES = `CFG_WR_CYCLES,
	parameter logic [6:0] DEV_ADDR  = `CFG_DEV_ADDR,
	parameter logic [7:0] MFR_CODE  = `CFG_MFR_CODE,
	parameter logic [7:0] PART_CODE = `CFG_PART_CODE
)
(
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	cfg_link_if.dev         link,
	output logic [7:0]      boot_byte_o,
	output logic            busy_o
);

	localparam int AW = $clog2(MEM_BYTES);

	// ==========================================================
	// helpers
	function automatic logic [23:0] inc_addr(input logic [23:0] a);
		if (a == 24'(MEM_BYTES - 1))
			return 24'h000000;
		return a + 24'h000001;
	endfunction

	// ==========================================================
	// pin synchronisers and line events
	logic scl_m, scl_s, scl_d;
	logic sda_m, sda_s, sda_d;
	logic sel_m, sel_s;

	always_ff @(posedge ref_clk_i)
	begin
		scl_m <= link.cfg_serial_clock;
		scl_s <= scl_m;
		scl_d <= scl_s;
		sda_m <= link.cfg_serial_data;
		sda_s <= sda_m;
		sda_d <= sda_s;
		sel_m <= link.programming_select_n;
		sel_s <= sel_m;
	end

	wire active   = ~sel_s;
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

	// ==========================================================
	// storage
	logic [7:0] mem [MEM_BYTES];

	dev_state_e  st_reg;
	rx_kind_e    kind_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  sh_reg;
	logic        rw_reg;
	logic [1:0]  ab_reg;
	logic [15:0] ahi_reg;
	logic [23:0] cur_reg;
	logic [23:0] wptr_reg;
	logic        wrote_reg;
	logic        oe_reg;
	logic [7:0]  tx_reg;
	logic        busy_reg;
	logic [31:0] busy_cnt;
	logic        boot_ld_reg;
	logic [7:0]  boot_reg;

	wire        id_hit   = cur_reg[23:1] == 23'(`CFG_ID_ADDR >> 1);
	wire        in_array = cur_reg < 24'(MEM_BYTES);
	wire [7:0]  arr_byte = mem[cur_reg[AW-1:0]];
	wire [7:0]  rd_data  = id_hit ? (cur_reg[0] ? PART_CODE : MFR_CODE) :
		in_array ? arr_byte : 8'hff;
	wire [7:0]  rx_next  = (kind_reg == K_DATA) ? {sda_s, sh_reg[7:1]} :
		{sh_reg[6:0], sda_s};
	wire        dev_hit  = (sh_reg[7:1] == DEV_ADDR) & ~busy_reg;
	wire [23:0] full_adr = {ahi_reg, sh_reg};
	wire [23:0] wptr_inc = {wptr_reg[23:`CFG_PAGE_BITS],
		wptr_reg[`CFG_PAGE_BITS-1:0] + `CFG_PAGE_BITS'(1)};
	wire        wr_byte  = (st_reg == D_RX) & scl_fall & (bit_reg == 4'h8) &
		(kind_reg == K_DATA) & active;
	wire        busy_go  = active & stop_ev & wrote_reg;

	// ==========================================================
	// array write, only the addressed page changes
	always_ff @(posedge ref_clk_i)
	begin
		if (wr_byte && wptr_reg < 24'(MEM_BYTES))
			mem[wptr_reg[AW-1:0]] <= sh_reg;
	end

	// ==========================================================
	// internally timed write cycle
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			busy_reg <= 1'b0;
			busy_cnt <= 32'h00000000;
		end
		else if (busy_go)
		begin
			busy_reg <= 1'b1;
			busy_cnt <= 32'(WR_CYCLES - 1);
		end
		else if (busy_reg)
		begin
			busy_reg <= busy_cnt != 32'h00000000;
			busy_cnt <= busy_cnt - 32'h00000001;
		end
	end

	// ==========================================================
	// boot byte cached once per reset
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			boot_ld_reg <= 1'b0;
			boot_reg    <= 8'h00;
		end
		else if (!boot_ld_reg)
		begin
			boot_ld_reg <= 1'b1;
			boot_reg    <= mem[0];
		end
	end

	// ==========================================================
	// protocol engine
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i || !active)
		begin
			st_reg    <= D_IDLE;
			kind_reg  <= K_DEV;
			bit_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			rw_reg    <= 1'b0;
			ab_reg    <= 2'h0;
			ahi_reg   <= 16'h0000;
			cur_reg   <= 24'h000000;
			wptr_reg  <= 24'h000000;
			wrote_reg <= 1'b0;
			oe_reg    <= 1'b0;
			tx_reg    <= 8'h00;
		end
		else if (start_ev)
		begin
			st_reg   <= D_RX;
			kind_reg <= K_DEV;
			bit_reg  <= 4'h0;
			oe_reg   <= 1'b0;
		end
		else if (stop_ev)
		begin
			st_reg    <= D_IDLE;
			oe_reg    <= 1'b0;
			wrote_reg <= 1'b0;
		end
		else
		begin
			case (st_reg)
				D_RX:
				begin
					if (scl_rise && bit_reg != 4'h8)
					begin
						sh_reg  <= rx_next;
						bit_reg <= bit_reg + 4'h1;
					end
					else if (scl_fall && bit_reg == 4'h8)
					begin
						oe_reg <= 1'b1;
						st_reg <= D_ACK;
						case (kind_reg)
							K_DEV:
							begin
								rw_reg <= sh_reg[0];
								ab_reg <= 2'h0;
								if (!dev_hit)
								begin
									oe_reg <= 1'b0;
									st_reg <= D_IDLE;
								end
							end
							K_ADDR:
							begin
								ahi_reg <= {ahi_reg[7:0], sh_reg};
								ab_reg  <= ab_reg + 2'h1;
								if (ab_reg == 2'h2)
								begin
									cur_reg  <= full_adr;
									wptr_reg <= full_adr;
									kind_reg <= K_DATA;
								end
							end
							default:
							begin
								wrote_reg <= 1'b1;
								cur_reg   <= inc_addr(wptr_reg);
								if (wptr_reg[`CFG_PAGE_BITS-1:0] == '1)
									cur_reg <= wptr_reg + 24'h000001;
								wptr_reg  <= wptr_inc;
							end
						endcase
					end
				end
				D_ACK:
				begin
					if (scl_fall)
					begin
						bit_reg <= 4'h0;
						st_reg  <= D_RX;
						oe_reg  <= 1'b0;
						if (kind_reg == K_DEV && rw_reg)
						begin
							tx_reg <= rd_data;
							oe_reg <= ~rd_data[0];
							st_reg <= D_TX;
						end
						else if (kind_reg == K_DEV)
							kind_reg <= K_ADDR;
					end
				end
				D_TX:
				begin
					if (scl_rise)
						bit_reg <= bit_reg + 4'h1;
					else if (scl_fall && bit_reg == 4'h8)
					begin
						oe_reg  <= 1'b0;
						st_reg  <= D_MACK;
						cur_reg <= inc_addr(cur_reg);
					end
					else if (scl_fall)
						oe_reg <= ~tx_reg[bit_reg[2:0]];
				end
				D_MACK:
				begin
					if (scl_rise && !sda_s)
					begin
						tx_reg  <= rd_data;
						bit_reg <= 4'h0;
						st_reg  <= D_TX;
					end
					else if (scl_rise)
						st_reg <= D_IDLE;
				end
				default:
					st_reg <= D_IDLE;
			endcase
		end
	end

	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = oe_reg;
	assign boot_byte_o     = boot_reg;
	assign busy_o          = busy_reg;

endmodule

`default_nettype wire

/* File: hdl/cfg_eeprom_consts.svh */
// constants shared by both ends of the configuration eeprom link
// assumes a 25 MHz reference clock on both ends
`ifndef CFG_EEPROM_CONSTS_SVH
`define CFG_EEPROM_CONSTS_SVH

// device address, seven bits, ahead of the read/write select bit
`define CFG_DEV_ADDR 7'h50
// identity readout address
`define CFG_ID_ADDR 24'h040000
// array size in bytes
`define CFG_MEM_BYTES 131072
// byte offset bits within a page (128-byte pages)
`define CFG_PAGE_BITS 7
// arbitrary maker code
`define CFG_MFR_CODE 8'h5a
// arbitrary part code
`define CFG_PART_CODE 8'ha5
// reference clock period
`define CFG_CLK_NS 40
// internally timed write cycle
`define CFG_TWR_MS 20
`define CFG_WR_CYCLES (`CFG_TWR_MS * 1000000 / `CFG_CLK_NS)
// least serial clock period, split into quarter phases
`define CFG_SCL_NS 10000
`define CFG_QTR_CYCLES ((`CFG_SCL_NS / 4 + `CFG_CLK_NS - 1) / `CFG_CLK_NS)

`endif

/* File: hdl/cfg_eeprom_pkg.sv */
// state and stage types for the configuration eeprom link
// assumes nothing beyond a SystemVerilog compiler
package cfg_eeprom_pkg;

	typedef enum logic [4:0]
	{
		D_IDLE = 5'h01,
		D_RX   = 5'h02,
		D_ACK  = 5'h04,
		D_TX   = 5'h08,
		D_MACK = 5'h10
	} dev_state_e;

	typedef enum logic [2:0]
	{
		K_DEV  = 3'h1,
		K_ADDR = 3'h2,
		K_DATA = 3'h4
	} rx_kind_e;

	typedef enum logic [3:0]
	{
		P_IDLE  = 4'h1,
		P_START = 4'h2,
		P_BYTE  = 4'h4,
		P_STOP  = 4'h8
	} prg_state_e;

	typedef enum logic [6:0]
	{
		S_DEVW  = 7'h01,
		S_A2    = 7'h02,
		S_A1    = 7'h04,
		S_A0    = 7'h08,
		S_DEVR  = 7'h10,
		S_WDATA = 7'h20,
		S_RDATA = 7'h40
	} stage_e;

endpackage

/* File: hdl/cfg_link_if.sv */
// two-wire programming link between programmer and eeprom
// assumes open-drain data line with pull-up, resolved here
`timescale 1ns/1ps
`default_nettype none

interface cfg_link_if;
	logic cfg_serial_clock;
	logic cfg_serial_data;
	logic prg_sda_o;
	logic prg_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic programming_select_n;
	logic fpga_reset_n;

	// open-drain: any enabled low driver pulls the line down
	assign cfg_serial_data = ~((prg_sda_oe & ~prg_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev
	(
		input  cfg_serial_clock,
		input  cfg_serial_data,
		input  programming_select_n,
		output dev_sda_o,
		output dev_sda_oe
	);

	modport prg
	(
		output cfg_serial_clock,
		input  cfg_serial_data,
		output prg_sda_o,
		output prg_sda_oe,
		output programming_select_n,
		output fpga_reset_n
	);
endinterface

`default_nettype wire

/* File: hdl/cfg_programmer.sv */
// programmer end of the two-wire link, makes the serial clock
// assumes a user command port on the same ref_clk_i domain
`timescale 1ns/1ps
`default_nettype none
`include "cfg_eeprom_consts.svh"

module cfg_programmer
	import cfg_eeprom_pkg::*;
#(
	parameter int         QTR      = `CFG_QTR_CYCLES,
	parameter logic [6:0] DEV_ADDR = `CFG_DEV_ADDR
)
(
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	cfg_link_if.prg          link,
	input  wire logic        isp_en_i,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_read_i,
	input  wire logic        cmd_random_i,
	input  wire logic [23:0] cmd_addr_i,
	input  wire logic [15:0] cmd_len_i,
	output logic             cmd_ready_o,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic        wr_valid_i,
	output logic             wr_ready_o,
	output logic [7:0]       rd_data_o,
	output logic             rd_valid_o,
	output logic             done_o,
	output logic             nack_o
);

	function automatic logic [7:0] stage_byte(input stage_e s, input logic [23:0] a);
		case (s)
			S_DEVW:  return {DEV_ADDR, 1'b0};
			S_DEVR:  return {DEV_ADDR, 1'b1};
			S_A2:    return a[23:16];
			S_A1:    return a[15:8];
			S_A0:    return a[7:0];
			default: return 8'h00;
		endcase
	endfunction

	// ==========================================================
	// data line synchroniser and phase timer
	logic sda_m, sda_s;
	always_ff @(posedge ref_clk_i)
	begin
		sda_m <= link.cfg_serial_data;
		sda_s <= sda_m;
	end

	prg_state_e  pst_reg;
	stage_e      stg_reg;
	logic [1:0]  ph_reg;
	logic [15:0] qc_reg;
	logic [3:0]  bi_reg;
	logic [7:0]  by_reg;
	logic [15:0] rem_reg;
	logic [23:0] adr_reg;
	logic        rd_reg, ack_reg;
	logic        scl_reg, oe_reg, sel_reg;
	logic        rdy_reg, wrr_reg, rdv_reg, done_reg, nack_reg;
	logic [7:0]  rdd_reg;

	wire tick    = qc_reg == 16'(QTR - 1);
	wire rx_stg  = stg_reg == S_RDATA;
	wire dat_stg = stg_reg == S_WDATA || rx_stg;
	wire wfirst  = stg_reg == S_WDATA && bi_reg == 4'h0;
	wire stall   = wfirst && !wr_valid_i;
	wire [7:0] cur_byte = wfirst ? wr_data_i : by_reg;
	wire tx_bit  = dat_stg ? cur_byte[bi_reg[2:0]] : cur_byte[3'h7 - bi_reg[2:0]];
	wire last    = rem_reg == 16'h0001;

	// ==========================================================
	// bit and byte sequencer
	always_ff @(posedge ref_clk_i)
	begin
		if (!rstn_i)
		begin
			pst_reg <= P_IDLE;
			stg_reg <= S_DEVW;
			ph_reg  <= 2'h0;
			qc_reg  <= 16'h0000;
			bi_reg  <= 4'h0;
			by_reg  <= 8'h00;
			rem_reg <= 16'h0000;
			adr_reg <= 24'h000000;
			rd_reg  <= 1'b0;
			ack_reg <= 1'b0;
			scl_reg <= 1'b1;
			oe_reg  <= 1'b0;
			sel_reg <= 1'b1;
			rdy_reg <= 1'b0;
			wrr_reg <= 1'b0;
			rdv_reg <= 1'b0;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
			rdd_reg <= 8'h00;
		end
		else
		begin
			sel_reg  <= ~isp_en_i;
			wrr_reg  <= 1'b0;
			rdv_reg  <= 1'b0;
			done_reg <= 1'b0;
			nack_reg <= 1'b0;
			qc_reg   <= (tick || pst_reg == P_IDLE || stall) ? 16'h0000 : qc_reg + 16'h0001;
			rdy_reg  <= pst_reg == P_IDLE && !sel_reg && !(cmd_valid_i && rdy_reg);
			if (pst_reg == P_IDLE)
			begin
				if (cmd_valid_i && rdy_reg)
				begin
					pst_reg <= P_START;
					ph_reg  <= 2'h0;
					rd_reg  <= cmd_read_i;
					adr_reg <= cmd_addr_i;
					rem_reg <= cmd_len_i;
					stg_reg <= (cmd_read_i && !cmd_random_i) ? S_DEVR : S_DEVW;
				end
			end
			else if (tick)
			begin
				ph_reg <= ph_reg + 2'h1;
				case (pst_reg)
					P_START:
					begin
						case (ph_reg)
							2'h0: oe_reg <= 1'b0;
							2'h1: scl_reg <= 1'b1;
							2'h2: oe_reg <= 1'b1;
							default:
							begin
								scl_reg <= 1'b0;
								pst_reg <= P_BYTE;
								bi_reg  <= 4'h0;
								by_reg  <= stage_byte(stg_reg, adr_reg);
							end
						endcase
					end
					P_BYTE:
					begin
						case (ph_reg)
							2'h0:
							begin
								if (bi_reg != 4'h8)
									oe_reg <= rx_stg ? 1'b0 : ~tx_bit;
								else
									oe_reg <= rx_stg && !last;
								if (wfirst)
								begin
									by_reg  <= wr_data_i;
									wrr_reg <= 1'b1;
								end
							end
							2'h1: scl_reg <= 1'b1;
							2'h2:
							begin
								if (rx_stg && bi_reg != 4'h8)
									by_reg <= {sda_s, by_reg[7:1]};
								ack_reg <= ~sda_s;
							end
							default:
							begin
								scl_reg <= 1'b0;
								bi_reg  <= bi_reg + 4'h1;
								if (bi_reg == 4'h8)
								begin
									bi_reg <= 4'h0;
									if (!rx_stg && !ack_reg)
									begin
										scl_reg  <= 1'b1; // write polling abandons, no stop
										oe_reg   <= 1'b0;
										nack_reg <= 1'b1;
										pst_reg  <= P_IDLE;
									end
									else
									begin
										case (stg_reg)
											S_DEVW: stg_reg <= S_A2;
											S_A2:   stg_reg <= S_A1;
											S_A1:   stg_reg <= S_A0;
											S_A0:
											begin
												stg_reg <= rd_reg ? S_DEVR : S_WDATA;
												if (rd_reg)
													pst_reg <= P_START;
											end
											S_DEVR: stg_reg <= S_RDATA;
											default:
											begin
												rem_reg <= rem_reg - 16'h0001;
												rdv_reg <= rx_stg;
												rdd_reg <= by_reg;
												if (last)
													pst_reg <= P_STOP;
											end
										endcase
										by_reg <= stage_byte(stg_reg == S_DEVW ? S_A2 :
											stg_reg == S_A2 ? S_A1 : S_A0, adr_reg);
									end
								end
							end
						endcase
					end
					default:
					begin
						case (ph_reg)
							2'h0: oe_reg <= 1'b1;
							2'h1: scl_reg <= 1'b1;
							2'h2: oe_reg <= 1'b0;
							default:
							begin
								done_reg <= 1'b1;
								pst_reg  <= P_IDLE;
							end
						endcase
					end
				endcase
			end
		end
	end

	assign link.cfg_serial_clock     = scl_reg;
	assign link.prg_sda_o            = 1'b0;
	assign link.prg_sda_oe           = oe_reg;
	assign link.programming_select_n = sel_reg;
	assign link.fpga_reset_n         = sel_reg;
	assign cmd_ready_o = rdy_reg;
	assign wr_ready_o  = wrr_reg;
	assign rd_data_o   = rdd_reg;
	assign rd_valid_o  = rdv_reg;
	assign done_o      = done_reg;
	assign nack_o      = nack_reg;

endmodule

`default_nettype wire

/* File: verification/cfg_link_monitor.sv */
// assertions on the two-wire link between programmer and eeprom
// assumes one reference clock domain, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module cfg_link_monitor
#(
	parameter int QTR = 2
)
(
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic cfg_serial_clock,
	input wire logic cfg_serial_data,
	input wire logic prg_sda_o,
	input wire logic prg_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic programming_select_n,
	input wire logic fpga_reset_n
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	// ==========================================
	// serial clock level run lengths
	int hi_cnt;
	int lo_cnt;
	always_ff @(posedge ref_clk_i)
	begin
		hi_cnt <= (!rstn_i || !cfg_serial_clock) ? 0 : hi_cnt + 1;
		lo_cnt <= (!rstn_i || cfg_serial_clock) ? 0 : lo_cnt + 1;
	end

	// ==========================================
	// assertions
	chk_prg_open_drain: assert property (prg_sda_oe |-> !prg_sda_o)
		else $error("programmer drives a high level");
	chk_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drives a high level");
	chk_reset_ties_select: assert property (fpga_reset_n == programming_select_n)
		else $error("fpga reset not tied to select");
	chk_quiet_unselected: assert property (programming_select_n[*5] |-> !dev_sda_oe)
		else $error("device drives while unselected");
	chk_scl_idle_unsel: assert property (programming_select_n |-> cfg_serial_clock)
		else $error("serial clock moves while unselected");
	chk_dev_edge_low: assert property
		(!programming_select_n && $changed(dev_sda_oe) |-> !cfg_serial_clock)
		else $error("device data changed with clock high");
	chk_dev_hold_high: assert property
		(!programming_select_n && cfg_serial_clock |-> $stable(dev_sda_oe))
		else $error("device data unstable while clock high");
	chk_scl_high_min: assert property ($fell(cfg_serial_clock) |-> hi_cnt >= 2 * QTR)
		else $error("serial clock high phase too short");
	chk_scl_low_min: assert property ($rose(cfg_serial_clock) |-> lo_cnt >= 2 * QTR)
		else $error("serial clock low phase too short");

	cov_start: cover property (cfg_serial_clock && $fell(cfg_serial_data));
	cov_stop: cover property (cfg_serial_clock && $rose(cfg_serial_data));
	cov_dev_ack: cover property ($rose(cfg_serial_clock) && dev_sda_oe);
	cov_select: cover property ($fell(programming_select_n));
endmodule

`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench: programmer and eeprom joined by the link
// assumes shortened write cycle and quarter phase parameters
`timescale 1ns/1ps
`default_nettype none
`include "cfg_eeprom_consts.svh"

module testbench;
	localparam int MEM = 1024;
	logic        ref_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        isp_en_i = 1'b0;
	logic        cmd_valid_i = 1'b0;
	logic        cmd_read_i = 1'b0;
	logic        cmd_random_i = 1'b0;
	logic [23:0] cmd_addr_i = 24'h000000;
	logic [15:0] cmd_len_i = 16'h0001;
	logic [7:0]  wr_data_i = 8'h00;
	logic        wr_valid_i = 1'b0;
	logic        cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, busy_o;
	logic [7:0]  rd_data_o, boot_byte_o, old0;
	logic [7:0]  mm [0:MEM-1];
	logic [7:0]  wbuf [0:127];
	logic [7:0]  rq [$];
	logic        got_nack;
	logic        scl_q = 1'b1;
	logic [10:0] sh = 11'h000;
	int          bad_count = 0;
	int          cmp_count = 0;

	always #20 ref_clk_i = ~ref_clk_i;

	// ==========================================
	// design ends and link
	cfg_link_if link ();
	cfg_eeprom_dev #(.MEM_BYTES(MEM), .WR_CYCLES(400)) u_cfg_eeprom_dev (.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i), .link(link.dev), .boot_byte_o(boot_byte_o), .busy_o(busy_o));
	cfg_programmer #(.QTR(2)) u_cfg_programmer (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.link(link.prg), .isp_en_i(isp_en_i), .cmd_valid_i(cmd_valid_i),
		.cmd_read_i(cmd_read_i), .cmd_random_i(cmd_random_i), .cmd_addr_i(cmd_addr_i),
		.cmd_len_i(cmd_len_i), .cmd_ready_o(cmd_ready_o), .wr_data_i(wr_data_i),
		.wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .done_o(done_o), .nack_o(nack_o));
	cfg_link_monitor #(.QTR(2)) u_cfg_link_monitor (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.cfg_serial_clock(link.cfg_serial_clock), .cfg_serial_data(link.cfg_serial_data),
		.prg_sda_o(link.prg_sda_o), .prg_sda_oe(link.prg_sda_oe),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
		.programming_select_n(link.programming_select_n), .fpga_reset_n(link.fpga_reset_n));

	// ==========================================
	// wire bits at each serial clock rise
	always @(posedge ref_clk_i)
	begin
		scl_q <= link.cfg_serial_clock;
		if (link.cfg_serial_clock && !scl_q)
			sh <= {sh[9:0], link.cfg_serial_data};
	end

	// ==========================================
	// helpers
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int j = 0; j < 8; j++)
			rev[j] = v[7 - j];
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("mismatches=%0d compares=%0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic hang();
		bad_count++;
		end_sim();
	endtask

	task automatic run(input logic rd, input logic rnd, input logic [23:0] a, input int n);
		int i;
		int k;
		i = 0;
		k = 0;
		rq.delete();
		cmd_read_i <= rd;
		cmd_random_i <= rnd;
		cmd_addr_i <= a;
		cmd_len_i <= 16'(n);
		wr_data_i <= wbuf[0];
		wr_valid_i <= !rd;
		cmd_valid_i <= 1'b1;
		do
		begin
			@(posedge ref_clk_i);
			k++;
		end
		while (cmd_ready_o !== 1'b1 && k < 100);
		cmd_valid_i <= 1'b0;
		if (k >= 100)
			hang();
		for (k = 0; k < 30000; k++)
		begin
			@(posedge ref_clk_i);
			if (wr_ready_o === 1'b1)
			begin
				i++;
				wr_data_i <= wbuf[i % 128];
			end
			if (rd_valid_o === 1'b1)
				rq.push_back(rd_data_o);
			if (done_o === 1'b1 || nack_o === 1'b1)
				break;
		end
		got_nack = nack_o;
		wr_valid_i <= 1'b0;
		if (k >= 30000)
			hang();
		if (!rd)
			chk(i, n);
	endtask

	task automatic wr_page(input int base);
		for (int j = 0; j < 128; j++)
			wbuf[j] = 8'($urandom);
		run(1'b0, 1'b0, 24'(base), 128);
		for (int j = 0; j < 128; j++)
			mm[base + j] = wbuf[j];
		chk(got_nack, 1'b0);
	endtask

	task automatic rd_chk(input logic rnd, input int a, input int n);
		run(1'b1, rnd, 24'(a), n);
		chk(got_nack, 1'b0);
		chk(rq.size(), n);
		for (int j = 0; j < n; j++)
			chk(rq[j], mm[(a + j) % MEM]);
		if (n == 1)
		begin
			chk(sh[9:2], rev(mm[a % MEM]));
			chk(sh[1], 1'b1);
			chk(sh[0], 1'b0);
		end
	endtask

	task automatic wait_idle();
		int k;
		for (k = 0; k < 20 && busy_o !== 1'b1; k++)
			@(posedge ref_clk_i);
		chk(busy_o, 1'b1);
		for (k = 0; k < 1000 && busy_o !== 1'b0; k++)
			@(posedge ref_clk_i);
		if (k >= 1000)
			hang();
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'ha57bf267));
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		isp_en_i <= 1'b1;
		wr_page(128);
		wait_idle();
		wr_page(0);
		wait_idle();
		rd_chk(1'b0, 128, 1);
		wr_page(896);
		run(1'b1, 1'b0, 24'h000000, 1);
		chk(got_nack, 1'b1);
		wait_idle();
		rd_chk(1'b1, 1022, 4);
		rd_chk(1'b0, 2, 1);
		run(1'b1, 1'b1, `CFG_ID_ADDR, 2);
		chk(rq[0], `CFG_MFR_CODE);
		chk(rq[1], `CFG_PART_CODE);
		rstn_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk(boot_byte_o, mm[0]);
		old0 = mm[0];
		wr_page(0);
		wait_idle();
		chk(boot_byte_o, old0);
		rd_chk(1'b1, 127, 2);
		isp_en_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		chk(cmd_ready_o, 1'b0);
		chk(link.fpga_reset_n, 1'b1);
		isp_en_i <= 1'b1;
		rd_chk(1'b0, 0, 1);
		end_sim();
	end
endmodule

`default_nettype wire
